// *** verilog/stts_trigger.sv ***
// Stereo trigger generator with timestamp clock and frame pairing.
// Operation
// - Primary trigger rate from 0.1 to 200 Hz.
// - Primary pulse high time set in milliseconds.
// - Triggers are active high, low when idle.
// - Each trigger output has its own enable.
// - Secondary works only while primary is enabled.
// - Secondary shares the primary repetition rate.
// - Secondary rises an offset after primary rise.
// - Secondary pulse width is set independently.
// - Optionally report trigger time as result stamp.
// - Pair frames only within maximum stamp difference.
// - Internal clock stamps every captured frame.
// - Seconds sync pulse clears the timestamp clock.
`timescale 1ns/1ns
`include "stts_defs.svh"
module stts_trigger
  import stts_pkg::*;
#(
  parameter int TS_W = `STTS_TS_W
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire stts_pkg::stts_trig_cfg_t primaryCfg,
  input  wire stts_pkg::stts_trig_cfg_t secondaryCfg,
  input  wire logic [15:0]             rateDeciHz,
  input  wire logic [15:0]             secondaryOffsetMs,
  input  wire logic                    useTriggerTime,
  input  wire logic                    syncEnable,
  input  wire logic                    seconds_sync_pulse,
  input  wire logic [47:0]             maxPairDiff,
  input  wire logic                    leftFrame,
  input  wire logic                    rightFrame,
  output logic                         trigPrimary,
  output logic                         trigSecondary,
  output logic [47:0]                  timestamp,
  output stts_pkg::stts_pair_t         pairOut,
  output logic                         pairDropped
);
  // All state of the top lives in one record.
  typedef struct packed {
    logic [31:0] periodCnt;
    logic [15:0] msCnt;
    logic        msTick;
    logic        periodStart;
    logic        primOn;
    logic        syncQ1;
    logic        syncQ2;
    logic        syncQ3;
    logic        leftQ1;
    logic        leftQ2;
    logic        leftQ3;
    logic        rightQ1;
    logic        rightQ2;
    logic        rightQ3;
    logic [47:0] ts;
    logic [47:0] lastTrig;
    logic        lHave;
    logic [47:0] lStamp;
    logic [47:0] lTrig;
    logic        rHave;
    logic [47:0] rStamp;
    logic [47:0] rTrig;
    stts_pair_t  pair;
    logic        drop;
  } stts_top_st_t;
  stts_top_st_t s;
  stts_top_st_t next_s;

  logic primPulse;
  logic secPulse;
  logic secEnable;
  logic [31:0] periodCycles;
  logic [15:0] rateClamp;

  // Absolute difference of two stamps, used for both pairing directions.
  function automatic logic [47:0] absDiff(input logic [47:0] a,
                                          input logic [47:0] b);
    absDiff = (a >= b) ? (a - b) : (b - a);
  endfunction

  // Rising edge of a synchronised pin, seen between stages two and three.
  function automatic logic pinRise(input logic q2, input logic q3);
    pinRise = q2 & ~q3;
  endfunction

  // Out-of-range rates are clamped rather than refused.
  always_comb begin
    rateClamp = rateDeciHz;
    if (rateDeciHz < `STTS_RATE_MIN) begin
      rateClamp = `STTS_RATE_MIN;
    end else if (rateDeciHz > `STTS_RATE_MAX) begin
      rateClamp = `STTS_RATE_MAX;
    end
  end
  // The divide is combinational; the rate is static configuration.
  assign periodCycles = 32'(`STTS_RATE_SCALE / 32'(rateClamp));

  // The secondary output is gated by the primary enable.
  assign secEnable = secondaryCfg.enable & primaryCfg.enable;

  always_comb begin
    next_s = s;
    next_s.msTick = 1'b0;
    next_s.periodStart = 1'b0;
    next_s.pair.valid = 1'b0;
    next_s.drop = 1'b0;
    next_s.primOn = primaryCfg.enable;

    // Input synchronisers; stages two and three feed the edge logic.
    next_s.syncQ1 = seconds_sync_pulse;
    next_s.syncQ2 = s.syncQ1;
    next_s.syncQ3 = s.syncQ2;
    next_s.leftQ1 = leftFrame;
    next_s.leftQ2 = s.leftQ1;
    next_s.leftQ3 = s.leftQ2;
    next_s.rightQ1 = rightFrame;
    next_s.rightQ2 = s.rightQ1;
    next_s.rightQ3 = s.rightQ2;

    // Millisecond tick from a divider restarted at each period start.
    if (s.msCnt >= 16'(`STTS_MS_CYCLES - 1)) begin
      next_s.msCnt = 16'h0000;
      next_s.msTick = 1'b1;
    end else begin
      next_s.msCnt = s.msCnt + 16'h0001;
    end

    // Period counter; re-enabling starts a fresh period at once.
    if (!primaryCfg.enable) begin
      next_s.periodCnt = 32'h00000000;
    end else if (!s.primOn || s.periodCnt >= periodCycles - 32'h1) begin
      next_s.periodCnt = 32'h00000000;
      next_s.periodStart = 1'b1;
      next_s.msCnt = 16'h0000;
    end else begin
      next_s.periodCnt = s.periodCnt + 32'h00000001;
    end

    // Free-running stamp clock, cleared by the sync pulse rising edge.
    if (syncEnable && pinRise(s.syncQ2, s.syncQ3)) begin
      next_s.ts = `STTS_TS_RESET;
    end else begin
      next_s.ts = s.ts + 48'h000000000001;
    end
    if (s.periodStart) begin
      next_s.lastTrig = s.ts;
    end

    // Frames are stamped on the rising edge of their capture strobe.
    if (pinRise(s.leftQ2, s.leftQ3)) begin
      next_s.lHave = 1'b1;
      next_s.lStamp = s.ts;
      next_s.lTrig = s.lastTrig;
    end
    if (pinRise(s.rightQ2, s.rightQ3)) begin
      next_s.rHave = 1'b1;
      next_s.rStamp = s.ts;
      next_s.rTrig = s.lastTrig;
    end

    // A held pair within range is emitted; otherwise the older is dropped.
    if (s.lHave && s.rHave) begin
      // A frame edge in this very cycle survives the clear, so none is lost.
      next_s.lHave = pinRise(s.leftQ2, s.leftQ3);
      next_s.rHave = pinRise(s.rightQ2, s.rightQ3);
      if (absDiff(s.lStamp, s.rStamp) <= maxPairDiff) begin
        next_s.pair.valid = 1'b1;
        next_s.pair.leftStamp = s.lStamp;
        next_s.pair.rightStamp = s.rStamp;
        next_s.pair.resultStamp = useTriggerTime ? s.lTrig
                                                 : s.lStamp;
      end else begin
        next_s.drop = 1'b1;
        if (s.lStamp > s.rStamp) begin
          next_s.lHave = 1'b1;
        end else begin
          next_s.rHave = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Primary fires with no delay; the secondary after its offset.
  stts_pulse u_primary (
    .clk     (clk),
    .rst_b   (rst_b),
    .enable  (primaryCfg.enable),
    .start   (s.periodStart),
    .delayMs (16'h0000),
    .widthMs (primaryCfg.widthMs),
    .msTick  (s.msTick),
    .pulse   (primPulse)
  );

  stts_pulse u_secondary (
    .clk     (clk),
    .rst_b   (rst_b),
    .enable  (secEnable),
    .start   (s.periodStart),
    .delayMs (secondaryOffsetMs),
    .widthMs (secondaryCfg.widthMs),
    .msTick  (s.msTick),
    .pulse   (secPulse)
  );

  // Outputs come straight from flops.
  assign trigPrimary = primPulse;
  assign trigSecondary = secPulse;
  assign timestamp = s.ts;
  assign pairOut = s.pair;
  assign pairDropped = s.drop;

  // Checks on the trigger outputs, the stamp clock and the pairing.
  // Each one guards a promise made to the cameras or to the host side.
  // Inputs appear only in antecedents, except maxPairDiff in pair_range_a; consequents watch what we drive.

  // Two disabled cycles on the primary leave the secondary low.
  sec_gated_a: assert property (@(posedge clk) disable iff (!rst_b)
    !primaryCfg.enable ##1 !primaryCfg.enable |-> !trigSecondary)
    else $error("secondary high without primary enable");

  // A pair leaves only when its stamps lie within the limit.
  pair_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    pairOut.valid |-> absDiff(pairOut.leftStamp, pairOut.rightStamp)
      <= $past(maxPairDiff)) else $error("pair out of range");

  // A sync edge while enabled zeroes the stamp clock on the next cycle.
  sync_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    syncEnable && pinRise(s.syncQ2, s.syncQ3) |=> timestamp == 48'h0)
    else $error("stamp not cleared by sync");

  // Without a sync clear the stamp clock advances by one each cycle.
  stamp_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(syncEnable && pinRise(s.syncQ2, s.syncQ3)) |=>
      timestamp == $past(timestamp) + 48'h000000000001)
    else $error("stamp clock did not advance");

  // A trigger time can never be later than the capture it caused.
  // A sync clear between trigger and capture would break this.
  trig_stamp_a: assert property (@(posedge clk) disable iff (!rst_b)
    pairOut.valid && $past(useTriggerTime) |->
      pairOut.resultStamp <= pairOut.leftStamp)
    else $error("trigger stamp later than capture");

  // With the option off, the result carries the left capture time.
  cap_stamp_a: assert property (@(posedge clk) disable iff (!rst_b)
    pairOut.valid && !$past(useTriggerTime) |->
      pairOut.resultStamp == pairOut.leftStamp)
    else $error("result stamp is not the capture time");

  // A pair and a drop never come out in the same cycle.
  pair_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(pairOut.valid && pairDropped))
    else $error("pair and drop together");

  // Every period start with a non-zero width raises the primary.
  prim_rise_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.periodStart && primaryCfg.enable && primaryCfg.widthMs != 16'h0
      |=> trigPrimary) else $error("primary missed period start");

  // The clamped period stays between the 200 Hz and 0.1 Hz lengths.
  rate_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    periodCycles >= 32'(`STTS_RATE_SCALE / `STTS_RATE_MAX) &&
      periodCycles <= `STTS_RATE_SCALE)
    else $error("trigger period outside rate range");

  // Period starts are single pulses, shared by both outputs.
  period_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.periodStart |=> !s.periodStart)
    else $error("period start longer than one cycle");

  // The millisecond tick is a one-cycle enable, never a level.
  tick_once_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.msTick |=> !s.msTick)
    else $error("millisecond tick longer than one cycle");

  // A disabled primary is low on the next cycle.
  prim_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    !primaryCfg.enable |=> !trigPrimary)
    else $error("primary high while disabled");

  // A disabled secondary is low on the next cycle.
  sec_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    !secondaryCfg.enable |=> !trigSecondary)
    else $error("secondary high while disabled");

  // A zero primary width never raises an idle primary.
  prim_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    primaryCfg.widthMs == 16'h0000 && !trigPrimary |=> !trigPrimary)
    else $error("primary rose with zero width");

  // A zero secondary width never raises an idle secondary.
  sec_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    secondaryCfg.widthMs == 16'h0000 && !trigSecondary |=> !trigSecondary)
    else $error("secondary rose with zero width");
endmodule // stts_trigger

// *** verilog/stts_defs.svh ***
// Timing constants and reset values for the stereo trigger and timestamp block.
`ifndef STTS_DEFS_SVH
`define STTS_DEFS_SVH
`define STTS_CLK_HZ        25000000
`define STTS_MS_NS         1000000
`define STTS_CLK_NS        40
// Cycles per millisecond, derived from the period.
`define STTS_MS_CYCLES     (`STTS_MS_NS / `STTS_CLK_NS)
// Rate is programmed in tenths of hertz: 1 is 0.1 Hz, 2000 is 200 Hz.
`define STTS_RATE_MIN      16'h0001
`define STTS_RATE_MAX      16'h07D0
// Clock cycles in one period at 1 Hz, times ten for the tenth-hertz scale.
`define STTS_RATE_SCALE    32'h0EE6B280
`define STTS_TS_W          48
`define STTS_TS_RESET      48'h000000000000
`endif

// *** verilog/stts_pkg.sv ***
// Types shared by the stereo trigger and timestamp block.
package stts_pkg;
  typedef struct packed {
    logic        enable;
    logic [15:0] widthMs;
  } stts_trig_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        right;
    logic [47:0] stamp;
  } stts_frame_t;

  typedef struct packed {
    logic        valid;
    logic [47:0] leftStamp;
    logic [47:0] rightStamp;
    logic [47:0] resultStamp;
  } stts_pair_t;
endpackage

// *** verilog/stts_pulse.sv ***
// One trigger output: delayed start, then a high time counted in milliseconds.
`timescale 1ns/1ns
`include "stts_defs.svh"
module stts_pulse
  import stts_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        enable,
  input  wire logic        start,
  input  wire logic [15:0] delayMs,
  input  wire logic [15:0] widthMs,
  input  wire logic        msTick,
  output logic             pulse
);
  typedef enum logic [1:0] {IDLE, WAIT, HIGH} stts_pstate_t;
  typedef struct packed {
    stts_pstate_t st;
    logic [15:0]  cnt;
    logic         out;
  } stts_pulse_st_t;
  stts_pulse_st_t s;
  stts_pulse_st_t next_s;

  // Delay and width both count whole millisecond ticks after the start.
  always_comb begin
    next_s = s;
    case (s.st)
      IDLE: begin
        if (start) begin
          next_s.cnt = 16'h0000;
          if (delayMs == 16'h0000) begin
            next_s.st = HIGH;
            next_s.out = (widthMs != 16'h0000);
          end else begin
            next_s.st = WAIT;
          end
        end
      end
      WAIT: begin
        if (msTick) begin
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt + 16'h0001 >= delayMs) begin
            next_s.st = HIGH;
            next_s.cnt = 16'h0000;
            next_s.out = (widthMs != 16'h0000);
          end
        end
      end
      HIGH: begin
        if (msTick) begin
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt + 16'h0001 >= widthMs) begin
            next_s.st = IDLE;
            next_s.out = 1'b0;
          end
        end
      end
      default: next_s.st = IDLE;
    endcase
    // A disabled output is held low and forgets any pending pulse.
    if (!enable) begin
      next_s.st = IDLE;
      next_s.out = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '{st: IDLE, cnt: 16'h0000, out: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.out;

  // A disabled output never goes high on the next cycle.
  held_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    !enable |=> !pulse) else $error("pulse high while disabled");
endmodule // stts_pulse

// *** verif/stts_cam_model.sv ***
// Behavioural camera that captures one frame per trigger rise, unless a later rise restarts its delay.
`timescale 1ns/1ns
module stts_cam_model (
  input  wire logic        clk,
  input  wire logic        trig,
  input  wire logic [15:0] delayCyc,
  output logic             frame
);
  logic trigOld;
  int   waitCnt;
  int   holdCnt;

  // Start state: idle with no exposure pending.
  initial begin
    frame = 1'b0;
    trigOld = 1'b0;
    waitCnt = -1;
    holdCnt = 0;
  end

  // Exposure starts on a rising edge only; a rise during a pending delay restarts it, skipping the older one.
  always @(posedge clk) begin
    trigOld <= trig;
    if (trig === 1'b1 && trigOld === 1'b0) begin
      waitCnt <= delayCyc;
    end else if (waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
    end else if (waitCnt == 0) begin
      frame   <= 1'b1;
      holdCnt <= 4;
      waitCnt <= -1;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end else begin
      frame <= 1'b0;
    end
  end
endmodule // stts_cam_model

// *** verif/stts_tb.sv ***
// Self-checking testbench for the stereo trigger and timestamp block.
`timescale 1ns/1ns
module tb;
  import stts_pkg::*;
  localparam int MS = 25000;
  logic           clk;
  logic           rst_b;
  stts_trig_cfg_t primaryCfg;
  stts_trig_cfg_t secondaryCfg;
  logic [15:0]    rateDeciHz;
  logic [15:0]    secondaryOffsetMs;
  logic           useTriggerTime;
  logic           syncEnable;
  logic           seconds_sync_pulse;
  logic [47:0]    maxPairDiff;
  logic           leftFrame;
  logic           rightFrame;
  logic           trigPrimary;
  logic           trigSecondary;
  logic [47:0]    timestamp;
  stts_pair_t     pairOut;
  logic           pairDropped;
  logic [15:0]    dlyLeft;
  logic [15:0]    dlyRight;
  stts_pair_t     lastPair;
  logic [47:0]    riseStamp;
  wire logic [1:0] trigs;
  int             pairCnt;
  int             dropCnt;
  int             errCount;
  int             testsRun;

  assign trigs = {trigSecondary, trigPrimary};

  stts_trigger dut_u (
    .clk(clk), .rst_b(rst_b), .primaryCfg(primaryCfg),
    .secondaryCfg(secondaryCfg), .rateDeciHz(rateDeciHz),
    .secondaryOffsetMs(secondaryOffsetMs),
    .useTriggerTime(useTriggerTime), .syncEnable(syncEnable),
    .seconds_sync_pulse(seconds_sync_pulse), .maxPairDiff(maxPairDiff),
    .leftFrame(leftFrame), .rightFrame(rightFrame),
    .trigPrimary(trigPrimary), .trigSecondary(trigSecondary),
    .timestamp(timestamp), .pairOut(pairOut), .pairDropped(pairDropped));
  stts_cam_model camLeft_u (.clk(clk), .trig(trigPrimary),
    .delayCyc(dlyLeft), .frame(leftFrame));
  stts_cam_model camRight_u (.clk(clk), .trig(trigSecondary),
    .delayCyc(dlyRight), .frame(rightFrame));

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  // Pair and drop strobes last one cycle, so every edge is watched.
  always @(posedge clk) begin
    if (pairOut.valid === 1'b1) begin
      lastPair <= pairOut;
      pairCnt  <= pairCnt + 1;
    end
    if (pairDropped === 1'b1) begin
      dropCnt <= dropCnt + 1;
    end
  end

  // Prints the verdict and stops the run.
  task automatic giveVerdict();
    if (errCount == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Range check; an unknown value never passes.
  task automatic chk(input string what, input logic [47:0] lo,
                     input logic [47:0] hi, input logic [47:0] got);
    testsRun++;
    if ($isunknown(got) || got < lo || got > hi) begin
      errCount++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Bounded wait for a trigger level; n counts the cycles spent.
  task automatic waitFor(input int idx, input logic lvl, input int bound,
                         output int n);
    n = 0;
    while (trigs[idx] !== lvl) begin
      @(negedge clk);
      n++;
      if (n > bound) begin
        errCount++;
        $display("[ERR] trigger %0d wait expected %0d seen timeout", idx, lvl);
        giveVerdict();
      end
    end
  endtask

  // One sync pulse on the pin, then time for it to cross the synchroniser.
  task automatic pulseSync();
    seconds_sync_pulse = 1'b1;
    repeat (4) @(negedge clk);
    seconds_sync_pulse = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic testSync();
    logic [47:0] t0;
    repeat (200) @(negedge clk);
    t0 = timestamp;
    repeat (10) @(negedge clk);
    chk("stamp step", t0 + 48'hA, t0 + 48'hA, timestamp);
    pulseSync();
    chk("stamp kept", t0 + 48'h12, t0 + 48'h20, timestamp);
    syncEnable = 1'b1;
    pulseSync();
    chk("stamp cleared", 48'h0, 48'h8, timestamp);
  endtask

  // Secondary rises one ms after primary and is twice as wide.
  task automatic testMain();
    int n;
    int s;
    int w;
    secondaryOffsetMs = 16'h0001;
    secondaryCfg = {1'b1, 16'h0002};
    useTriggerTime = 1'b1;
    maxPairDiff = 48'h7530;
    primaryCfg = {1'b1, 16'h0001};
    waitFor(0, 1'b1, 4, n);
    chk("primary start", 48'h1, 48'h3, 48'(n));
    riseStamp = timestamp;
    waitFor(0, 1'b0, MS + 4, n);
    chk("primary width", 48'(MS), 48'(MS), 48'(n));
    waitFor(1, 1'b1, 8, s);
    chk("offset", 48'(MS - 2), 48'(MS + 2), 48'(n + s));
    waitFor(1, 1'b0, 2 * MS + 4, w);
    chk("second width", 48'(2*MS - 2), 48'(2*MS + 2), 48'(w));
    chk("pairs", 48'h1, 48'h1, 48'(pairCnt));
    chk("left stamp", riseStamp + 48'hA, riseStamp + 48'h10,
        lastPair.leftStamp);
    chk("result", riseStamp - 48'h3, riseStamp + 48'h3,
        lastPair.resultStamp);
    chk("right stamp", lastPair.leftStamp + 48'(MS - 2),
        lastPair.leftStamp + 48'(MS + 2), lastPair.rightStamp);
    primaryCfg.enable = 1'b0;
    secondaryCfg.enable = 1'b0;
  endtask

  // Secondary alone is enabled, so neither output may move.
  task automatic testSuppress();
    int hits;
    hits = 0;
    secondaryCfg.enable = 1'b1;
    repeat (300) begin
      @(negedge clk);
      if (trigs !== 2'b00) hits++;
    end
    chk("suppressed", 48'h0, 48'h0, 48'(hits));
  endtask

  // Frames 1990 cycles apart against a limit of 100, then abort mid-pulse.
  task automatic testDrop();
    int p0;
    int d0;
    int k;
    p0 = pairCnt;
    d0 = dropCnt;
    secondaryOffsetMs = 16'h0000;
    dlyRight = 16'h07D0;
    maxPairDiff = 48'h64;
    primaryCfg = {1'b1, 16'h0001};
    for (k = 0; k < 3000 && dropCnt == d0; k++) @(negedge clk);
    chk("dropped", 48'h1, 48'h1, 48'(dropCnt - d0));
    chk("no pair", 48'h0, 48'h0, 48'(pairCnt - p0));
    primaryCfg.enable = 1'b0;
    repeat (3) @(negedge clk);
    chk("abort low", 48'h0, 48'h0, 48'(trigs));
  endtask

  // Restart with equal delays and capture stamps, then reset mid-pulse.
  task automatic testCapture();
    int p0;
    int k;
    logic [47:0] t0;
    p0 = pairCnt;
    useTriggerTime = 1'b0;
    dlyRight = 16'h000A;
    maxPairDiff = 48'h0;
    t0 = timestamp;
    primaryCfg.enable = 1'b1;
    for (k = 0; k < 40 && pairCnt == p0; k++) @(negedge clk);
    chk("restart pair", 48'h1, 48'h1, 48'(pairCnt - p0));
    chk("cap time", t0 + 48'hC, t0 + 48'h14, lastPair.leftStamp);
    chk("cap result", lastPair.leftStamp, lastPair.leftStamp,
        lastPair.resultStamp);
    rst_b = 1'b0;
    @(negedge clk);
    chk("reset trig", 48'h0, 48'h0, 48'(trigs));
    chk("reset stamp", 48'h0, 48'h0, timestamp);
    rst_b = 1'b1;
    primaryCfg.enable = 1'b0;
    @(negedge clk);
    chk("stamp restart", 48'h1, 48'h1, timestamp);
    chk("idle after reset", 48'h0, 48'h0, 48'(trigs));
  endtask

  // Reset, then every scenario in turn.
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    primaryCfg = {1'b0, 16'h0001};
    secondaryCfg = {1'b0, 16'h0001};
    rateDeciHz = 16'h07D0;
    secondaryOffsetMs = 16'h0001;
    useTriggerTime = 1'b0;
    syncEnable = 1'b0;
    seconds_sync_pulse = 1'b0;
    maxPairDiff = 48'h64;
    dlyLeft = 16'h000A;
    dlyRight = 16'h000A;
    pairCnt = 0;
    dropCnt = 0;
    errCount = 0;
    testsRun = 0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk("idle triggers", 48'h0, 48'h0, 48'(trigs));
    testSync();
    testMain();
    testSuppress();
    testDrop();
    testCapture();
    giveVerdict();
  end
endmodule // tb
